// >>> hw/adccr_field_map.sv
module adccr_field_map (
	input  wire logic [7:0]  idx,
	input  wire logic [15:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic [15:0] cur,
	output logic      [15:0] rw_mask,
	output logic      [15:0] merged,
	output logic             hit
);
	logic [15:0] lane;

	// ----------------------------------------
	// Writable bits per register
	// ----------------------------------------
	always_comb begin
		hit     = 1'b1;
		rw_mask = 16'h0000;
		if (idx == adccr_pkg::IDX_CHAN2_OFFSET_LOW) begin
			rw_mask = 16'hff00; // [R02]
		end else if (idx == adccr_pkg::IDX_CHAN2_GAIN_HIGH) begin
			rw_mask = 16'hffff; // [R04]
		end else if (idx == adccr_pkg::IDX_CHAN2_GAIN_LOW) begin
			rw_mask = 16'hff00; // [R02]
		end else if (idx == adccr_pkg::IDX_CHAN3_CONFIG) begin
			rw_mask = 16'hffc7; // [R12]
		end else if (idx == adccr_pkg::IDX_CHAN3_OFFSET_HIGH) begin
			rw_mask = 16'hffff; // [R11]
		end else begin
			hit = 1'b0;
		end
		lane   = {{8{wstrb[1]}}, {8{wstrb[0]}}};
		// Reserved bits keep their stored zero whatever is written
		merged = (cur & ~(rw_mask & lane)) | (wdata & rw_mask & lane); // [R13]
	end
endmodule

// >>> hw/adccr_pkg.sv
package adccr_pkg;

	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	// Printed offsets are not multiples of four: byte address is four times the index
	localparam logic [7:0] IDX_CHAN2_OFFSET_LOW  = 8'h15;
	localparam logic [7:0] IDX_CHAN2_GAIN_HIGH   = 8'h16;
	localparam logic [7:0] IDX_CHAN2_GAIN_LOW    = 8'h17;
	localparam logic [7:0] IDX_CHAN3_CONFIG      = 8'h18;
	localparam logic [7:0] IDX_CHAN3_OFFSET_HIGH = 8'h19;
	localparam int         ADDR_W                = 8;

	// ----------------------------------------
	// Reset values and field layout
	// ----------------------------------------
	localparam logic [15:0] GAIN_HIGH_RESET = 16'h8000;
	localparam logic [15:0] ZERO16          = 16'h0000;
	localparam int          CFG_PHASE_LSB   = 6;
	localparam int          CFG_DCOFF_BIT   = 2;
	localparam logic [1:0]  AXI_OKAY        = 2'h0;
	localparam logic [1:0]  AXI_SLVERR      = 2'h2;

	typedef enum logic [1:0] {
		ADCCR_IN_OWN_PINS = 2'h0,
		ADCCR_IN_SHORTED  = 2'h1,
		ADCCR_IN_TEST_POS = 2'h2,
		ADCCR_IN_TEST_NEG = 2'h3
	} adccr_input_type;

	typedef struct packed {
		logic [9:0]      phase_delay;
		logic [2:0]      reserved;
		logic            dc_filter_off;
		adccr_input_type input_select;
	} adccr_cfg_type;

	// Calibration values presented to the channel datapath
	typedef struct packed {
		logic [23:0] chan2_gain;
		logic [7:0]  chan2_offset_low_bits;
		logic [15:0] chan3_offset_high_bits;
		logic [9:0]  chan3_phase_delay;
		logic        chan3_dc_filter_active;
		adccr_input_type chan3_input_select;
	} adccr_out_type;

	typedef enum logic [1:0] {
		ADCCR_IDLE = 2'b00,
		ADCCR_RESP = 2'b01
	} adccr_state_type;

endpackage

// >>> hw/adccr_regs.sv
// Operation
// [R01] Channel 2 offset low word keeps offset bits 7..0 in its upper byte, read/write, reset zero.
// [R02] The lower byte of each calibration low word always reads zero whatever was written.
// [R03] Channel 2 gain high word at 0x16 resets to 0x8000, a unity gain.
// [R04] Channel 2 gain high word supplies gain bits 23..8 over all 16 bits, read/write.
// [R05] Channel 2 gain low word at 0x17 supplies gain bits 7..0 in its upper byte, reset zero.
// [R06] The 24-bit gain is an unsigned fraction from 0.0 to just under 2.0.
// [R07] Channel 3 configuration at 0x18 resets to 0x0000.
// [R08] A 10-bit signed channel 3 phase field delays the channel in modulator cycles, reset zero.
// [R09] Channel 3 DC filter follows the global setting when its disable bit is 0, bypassed when 1.
// [R10] Channel 3 input select: 00 own pins, 01 shorted, 10 positive test, 11 negative test.
// [R11] Channel 3 offset high word at 0x19 holds offset bits 23..8, read/write, reset zero.
// [R12] The three reserved configuration bits are read-only zero.
// [R13] Writes to reserved bits are ignored and change no stored state.
module adccr_regs (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [9:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [9:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 global_dc_filter_setting,
	output adccr_pkg::adccr_out_type  cal_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0]                chan2_offset_low;
		logic [15:0]                chan2_gain_high;
		logic [15:0]                chan2_gain_low;
		adccr_pkg::adccr_cfg_type   chan3_cfg;
		logic [15:0]                chan3_offset_high;
		logic                       aw_held;
		logic [7:0]                 aw_idx;
		logic                       w_held;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		adccr_pkg::adccr_state_type wr_state;
		logic [1:0]                 bresp;
		adccr_pkg::adccr_state_type rd_state;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		adccr_pkg::adccr_out_type   out;
		logic                       awready;
		logic                       wready;
		logic                       arready;
	} adccr_regs_type;

	adccr_regs_type state_q;
	adccr_regs_type state_d;

	logic [15:0] cur_word;
	logic [15:0] merged;
	logic        wr_hit;
	logic [15:0] rd_word;
	logic        rd_hit;
	logic        wr_go;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;

	function automatic logic [7:0] addr_to_idx(input logic [9:0] a);
		addr_to_idx = a[9:2];
	endfunction

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	function automatic logic [16:0] read_word(input adccr_regs_type s, input logic [7:0] idx);
		read_word = {1'b1, 16'h0000};
		if (idx == adccr_pkg::IDX_CHAN2_OFFSET_LOW) begin
			read_word[15:0] = {s.chan2_offset_low[15:8], 8'h00}; // [R02]
		end else if (idx == adccr_pkg::IDX_CHAN2_GAIN_HIGH) begin
			read_word[15:0] = s.chan2_gain_high;
		end else if (idx == adccr_pkg::IDX_CHAN2_GAIN_LOW) begin
			read_word[15:0] = {s.chan2_gain_low[15:8], 8'h00}; // [R02]
		end else if (idx == adccr_pkg::IDX_CHAN3_CONFIG) begin
			read_word[15:0] = {s.chan3_cfg.phase_delay, 3'h0, s.chan3_cfg.dc_filter_off,
				s.chan3_cfg.input_select}; // [R12]
		end else if (idx == adccr_pkg::IDX_CHAN3_OFFSET_HIGH) begin
			read_word[15:0] = s.chan3_offset_high;
		end else begin
			read_word[16] = 1'b0;
		end
	endfunction

	// A channel is taken only on an edge where its own ready is seen high
	assign aw_take = s_axi_awvalid && state_q.awready;
	assign w_take  = s_axi_wvalid && state_q.wready;
	assign ar_take = s_axi_arvalid && state_q.arready;
	assign wr_go   = state_q.aw_held && state_q.w_held;

	always_comb begin
		cur_word = 16'h0000;
		if (state_q.aw_idx == adccr_pkg::IDX_CHAN2_OFFSET_LOW) begin
			cur_word = state_q.chan2_offset_low;
		end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN2_GAIN_HIGH) begin
			cur_word = state_q.chan2_gain_high;
		end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN2_GAIN_LOW) begin
			cur_word = state_q.chan2_gain_low;
		end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN3_CONFIG) begin
			cur_word = state_q.chan3_cfg;
		end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN3_OFFSET_HIGH) begin
			cur_word = state_q.chan3_offset_high;
		end
	end

	adccr_field_map u_map (
		.idx     (state_q.aw_idx),
		.wdata   (state_q.w_data[15:0]),
		.wstrb   (state_q.w_strb),
		.cur     (cur_word),
		.rw_mask (),
		.merged  (merged),
		.hit     (wr_hit)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		{rd_hit, rd_word} = read_word(state_q, addr_to_idx(s_axi_araddr));

		// Address and data may arrive in either order; each is held until both are in
		if (aw_take) begin
			state_d.aw_held = 1'b1;
			state_d.aw_idx  = addr_to_idx(s_axi_awaddr);
		end
		if (w_take) begin
			state_d.w_held = 1'b1;
			state_d.w_data = s_axi_wdata;
			state_d.w_strb = s_axi_wstrb;
		end

		case (state_q.wr_state)
			adccr_pkg::ADCCR_IDLE: begin
				if (wr_go) begin
					state_d.aw_held  = 1'b0;
					state_d.w_held   = 1'b0;
					state_d.wr_state = adccr_pkg::ADCCR_RESP;
					state_d.bresp    = wr_hit ? adccr_pkg::AXI_OKAY : adccr_pkg::AXI_SLVERR;
					if (state_q.aw_idx == adccr_pkg::IDX_CHAN2_OFFSET_LOW) begin
						state_d.chan2_offset_low = merged; // [R01]
					end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN2_GAIN_HIGH) begin
						state_d.chan2_gain_high = merged; // [R04]
					end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN2_GAIN_LOW) begin
						state_d.chan2_gain_low = merged; // [R05]
					end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN3_CONFIG) begin
						state_d.chan3_cfg = adccr_pkg::adccr_cfg_type'(merged); // [R08]
					end else if (state_q.aw_idx == adccr_pkg::IDX_CHAN3_OFFSET_HIGH) begin
						state_d.chan3_offset_high = merged; // [R11]
					end
				end
			end
			adccr_pkg::ADCCR_RESP: begin
				if (s_axi_bready) begin
					state_d.wr_state = adccr_pkg::ADCCR_IDLE;
				end
			end
			default: begin
				state_d.wr_state = adccr_pkg::ADCCR_IDLE;
			end
		endcase

		case (state_q.rd_state)
			adccr_pkg::ADCCR_IDLE: begin
				if (ar_take) begin
					state_d.rd_state = adccr_pkg::ADCCR_RESP;
					state_d.rdata    = {16'h0000, rd_word};
					state_d.rresp    = rd_hit ? adccr_pkg::AXI_OKAY : adccr_pkg::AXI_SLVERR;
				end
			end
			adccr_pkg::ADCCR_RESP: begin
				if (s_axi_rready) begin
					state_d.rd_state = adccr_pkg::ADCCR_IDLE;
				end
			end
			default: begin
				state_d.rd_state = adccr_pkg::ADCCR_IDLE;
			end
		endcase

		// Datapath view is loaded on the same edge as the registers it copies
		// Gain is an unsigned fraction: bit 23 weighs 1.0, so 0x800000 is unity
		state_d.out.chan2_gain = {state_d.chan2_gain_high, state_d.chan2_gain_low[15:8]}; // [R06]
		state_d.out.chan2_offset_low_bits  = state_d.chan2_offset_low[15:8]; // [R01]
		state_d.out.chan3_offset_high_bits = state_d.chan3_offset_high; // [R11]
		state_d.out.chan3_phase_delay      = state_d.chan3_cfg.phase_delay; // [R08]
		state_d.out.chan3_dc_filter_active = global_dc_filter_setting
			&& !state_d.chan3_cfg.dc_filter_off; // [R09]
		state_d.out.chan3_input_select     = state_d.chan3_cfg.input_select; // [R10]
		// Ready means the slot is free; reset holds it low until the first edge after release
		state_d.awready = !state_d.aw_held && state_d.wr_state == adccr_pkg::ADCCR_IDLE;
		state_d.wready  = !state_d.w_held && state_d.wr_state == adccr_pkg::ADCCR_IDLE;
		state_d.arready = state_d.rd_state == adccr_pkg::ADCCR_IDLE;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q                  <= '0;
			state_q.chan2_offset_low <= adccr_pkg::ZERO16;
			state_q.chan2_gain_high  <= adccr_pkg::GAIN_HIGH_RESET; // [R03]
			state_q.chan2_gain_low   <= adccr_pkg::ZERO16; // [R05]
			state_q.chan3_cfg        <= adccr_pkg::ZERO16; // [R07]
			state_q.out.chan2_gain   <= {adccr_pkg::GAIN_HIGH_RESET, 8'h00}; // [R03]
			state_q.wr_state         <= adccr_pkg::ADCCR_IDLE;
			state_q.rd_state         <= adccr_pkg::ADCCR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------
	// Ready is a registered "slot free" flag, so the slave never stalls on decode
	assign s_axi_awready = state_q.awready;
	assign s_axi_wready  = state_q.wready;
	assign s_axi_arready = state_q.arready;
	assign s_axi_bvalid  = state_q.wr_state == adccr_pkg::ADCCR_RESP;
	assign s_axi_bresp   = state_q.bresp;
	assign s_axi_rvalid  = state_q.rd_state == adccr_pkg::ADCCR_RESP;
	assign s_axi_rdata   = state_q.rdata;
	assign s_axi_rresp   = state_q.rresp;
	assign cal_out       = state_q.out;

endmodule

// >>> test/adccr_properties.sv
// ----------------------------------------
// Port-level checks for the calibration register bank
// ----------------------------------------
module adccr_props_chk (
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic [9:0]               s_axi_awaddr,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic [31:0]              s_axi_wdata,
	input wire logic [3:0]               s_axi_wstrb,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic [9:0]               s_axi_araddr,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic                     s_axi_rvalid,
	input wire logic                     global_dc_filter_setting,
	input wire adccr_pkg::adccr_out_type cal_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rd_idx_q;
	logic       wr_take;
	// Both channels taken on one edge; the bench always offers them together
	assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			rd_idx_q <= s_axi_araddr[9:2];
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_gain_unity: assert property ($rose(aresetn) |->
		cal_out.chan2_gain == 24'h80_0000) else $error("gain not unity after reset");
	a_reset_cfg_zero: assert property ($rose(aresetn) |->
		cal_out.chan3_phase_delay == 10'h000
		&& cal_out.chan3_input_select == adccr_pkg::ADCCR_IN_OWN_PINS
		&& cal_out.chan3_offset_high_bits == 16'h0000) else $error("config not zero after reset");
	a_low_byte_zero: assert property (s_axi_rvalid
		&& (rd_idx_q == 8'h15 || rd_idx_q == 8'h17)
		|-> s_axi_rdata[7:0] == 8'h00) else $error("low word lower byte not zero");
	a_cfg_resv_zero: assert property (s_axi_rvalid && rd_idx_q == 8'h18
		|-> s_axi_rdata[5:3] == 3'b000) else $error("config reserved bits not zero");
	a_dc_global_off: assert property ($past(aresetn) && !$past(global_dc_filter_setting)
		|-> !cal_out.chan3_dc_filter_active) else $error("filter active with global off");
	a_gain_high_write: assert property (wr_take && s_axi_awaddr[9:2] == 8'h16
		&& s_axi_wstrb[1:0] == 2'b11 |-> ##2 cal_out.chan2_gain[23:8] == $past(s_axi_wdata[15:0], 2))
		else $error("gain high word not applied");
	a_off_low_write: assert property (wr_take && s_axi_awaddr[9:2] == 8'h15
		&& s_axi_wstrb[1] |-> ##2 cal_out.chan2_offset_low_bits == $past(s_axi_wdata[15:8], 2))
		else $error("offset low bits not applied");
	a_cfg_field_write: assert property (wr_take && s_axi_awaddr[9:2] == 8'h18
		&& s_axi_wstrb[1:0] == 2'b11 |-> ##2 cal_out.chan3_phase_delay == $past(s_axi_wdata[15:6], 2)
		&& cal_out.chan3_input_select == $past(s_axi_wdata[1:0], 2)) else $error("config not applied");
	a_off_high_write: assert property (wr_take && s_axi_awaddr[9:2] == 8'h19
		&& s_axi_wstrb[1:0] == 2'b11
		|-> ##2 cal_out.chan3_offset_high_bits == $past(s_axi_wdata[15:0], 2))
		else $error("offset high word not applied");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

bind adccr_regs adccr_props_chk u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.global_dc_filter_setting(global_dc_filter_setting), .cal_out(cal_out));

// >>> test/test_adc_channel_calib_regs.sv
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_adc_channel_calib_regs;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals and device
	// ----------------------------------------
	logic                     aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic                     s_axi_arvalid, s_axi_rready, global_dc_filter_setting;
	logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [9:0]               s_axi_awaddr, s_axi_araddr;
	logic [31:0]              s_axi_wdata, s_axi_rdata;
	logic [3:0]               s_axi_wstrb;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	adccr_pkg::adccr_out_type cal_out;
	int                       checks = 0;
	int                       mismatches = 0;
	logic [9:0]  addr_t [5] = '{10'h054, 10'h058, 10'h05c, 10'h060, 10'h064};
	logic [15:0] rst_t [5]  = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
	logic [15:0] full_t [5] = '{16'hff00, 16'hffff, 16'hff00, 16'hffc7, 16'hffff};
	adccr_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .global_dc_filter_setting(global_dc_filter_setting),
		.cal_out(cal_out));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Handshakes are judged at the falling edge: the slave's flags come from flops,
	// so this equals what the next rising edge sees and avoids a race with it
	task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] rsp;
		b_t = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, rsp)
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] e, input logic [1:0] er);
		logic ar_t, r_t;
		logic [31:0] dat;
		logic [1:0] rsp;
		r_t = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			dat = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		`CHK("rdata", {16'h0000, e}, dat)
		`CHK("rresp", er, rsp)
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		#125000;
		mismatches++;
		finish_test();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		global_dc_filter_setting = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd(addr_t[i], rst_t[i], adccr_pkg::AXI_OKAY);
		@(negedge aclk);
		`CHK("gain", 24'h80_0000, cal_out.chan2_gain)
		$display("test reset values done");
		for (int i = 0; i < 5; i++) begin
			wr(addr_t[i], 16'hffff, 4'hf, adccr_pkg::AXI_OKAY);
			rd(addr_t[i], full_t[i], adccr_pkg::AXI_OKAY);
		end
		@(negedge aclk);
		`CHK("gain", 24'hff_ffff, cal_out.chan2_gain)
		`CHK("offset low", 8'hff, cal_out.chan2_offset_low_bits)
		`CHK("offset high", 16'hffff, cal_out.chan3_offset_high_bits)
		wr(10'h058, 16'h1234, 4'h2, adccr_pkg::AXI_OKAY);
		rd(10'h058, 16'h12ff, adccr_pkg::AXI_OKAY);
		$display("test write readback done");
		for (int k = 0; k < 16; k++) begin
			global_dc_filter_setting <= k[3];
			wr(10'h060, {10'h201, 3'b111, k[2], k[1:0]}, 4'h3, adccr_pkg::AXI_OKAY);
			@(negedge aclk);
			`CHK("select", k[1:0], cal_out.chan3_input_select)
			`CHK("phase", 10'h201, cal_out.chan3_phase_delay)
			`CHK("dc filter", k[3] & ~k[2], cal_out.chan3_dc_filter_active)
		end
		rd(10'h060, 16'h8047, adccr_pkg::AXI_OKAY);
		$display("test config codes done");
		wr(10'h068, 16'h5555, 4'hf, adccr_pkg::AXI_SLVERR);
		rd(10'h068, 16'h0000, adccr_pkg::AXI_SLVERR);
		rd(10'h050, 16'h0000, adccr_pkg::AXI_SLVERR);
		rd(10'h064, 16'hffff, adccr_pkg::AXI_OKAY);
		$display("test unmapped done");
		wr(10'h058, 16'h0000, 4'h3, adccr_pkg::AXI_OKAY);
		wr(10'h05c, 16'h01ff, 4'h3, adccr_pkg::AXI_OKAY);
		rd(10'h05c, 16'h0100, adccr_pkg::AXI_OKAY);
		@(negedge aclk);
		`CHK("gain lsb", 24'h00_0001, cal_out.chan2_gain)
		$display("test gain fraction done");
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(10'h058, 16'h8000, adccr_pkg::AXI_OKAY);
		rd(10'h060, 16'h0000, adccr_pkg::AXI_OKAY);
		$display("test second reset done");
		finish_test();
	end
endmodule
